// ---- core/acrb_top.sv ----
/*
 amp control register bank with its two-wire serial slave port.
 assumes scl and sda come from pins (synchronised here) and that sda is an
 open-drain wire pulled high outside; the lower clip threshold bits come from
 logic on the same clock.
*/
`timescale 1ns/1ps
module acrb_top #(
   parameter logic [6:0] DEV_ADDR = acrb_pkg::DEV_ADDR_DEF
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic [7:0] clip_mid_in,
   input wire logic [5:0] clip_low_in,
   output acrb_pkg::acrb_ctrl_t ctrl_out,
   output logic [19:0] clip_threshold_out,
   output logic power_stage_en_out,
   output logic logic_supply_en_out
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX = 5'h02,
      ST_ACK = 5'h04,
      ST_TX = 5'h08,
      ST_MACK = 5'h10
   } acrb_st_t;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_p;
      logic sda_s1;
      logic sda_s2;
      logic sda_p;
      acrb_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic [1:0] idx;
      logic rw;
      logic nack;
      logic oe;
      acrb_pkg::acrb_wr_t wr;
   } acrb_state_t;

   acrb_state_t q, d;
   logic [7:0] rd_data;
   logic start, stop, rise, fall;

   // bus conditions from the synchronised and delayed pin levels
   assign rise = q.scl_s2 & ~q.scl_p;
   assign fall = ~q.scl_s2 & q.scl_p;
   assign start = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
   assign stop = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;

   // protocol engine
   always_comb begin
      d = q;
      d.scl_s1 = scl_in;
      d.scl_s2 = q.scl_s1;
      d.scl_p = q.scl_s2;
      d.sda_s1 = sda_in;
      d.sda_s2 = q.sda_s1;
      d.sda_p = q.sda_s2;
      d.wr.en = 1'b0;
      if (start) begin
         // start or repeated start: next byte is the device address
         d.st = ST_RX;
         d.cnt = 4'h0;
         d.idx = 2'h0;
         d.oe = 1'b0;
      end else if (stop) begin
         d.st = ST_IDLE;
         d.oe = 1'b0;
      end else begin
         case (q.st)
            ST_RX: begin
               if (rise) begin
                  d.sh = {q.sh[6:0], q.sda_s2};
                  d.cnt = q.cnt + 4'h1;
               end
               if (fall && q.cnt == 4'h8) begin
                  d.cnt = 4'h0;
                  d.st = ST_ACK;
                  d.oe = 1'b1; // acknowledge each received byte, except a foreign device address
                  if (q.idx != 2'h3) begin
                     d.idx = q.idx + 2'h1;
                  end
                  case (q.idx)
                     2'h0: begin
                        d.rw = q.sh[0]; // direction bit, 1 selects read
                        if (q.sh[7:1] != DEV_ADDR) begin
                           d.st = ST_IDLE;
                           d.oe = 1'b0;
                        end
                     end
                     2'h1: d.ptr = q.sh; // register address byte
                     default: begin
                        d.wr = '{en: 1'b1, addr: q.ptr, data: q.sh};
                        d.ptr = q.ptr + 8'h01;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (fall) begin
                  if (q.rw) begin
                     // present the first read bit while scl is low
                     d.st = ST_TX;
                     d.sh = rd_data;
                     d.oe = ~rd_data[7];
                     d.cnt = 4'h0;
                  end else begin
                     d.st = ST_RX;
                     d.oe = 1'b0;
                  end
               end
            end
            ST_TX: begin
               if (rise) begin
                  d.cnt = q.cnt + 4'h1;
               end
               if (fall) begin
                  if (q.cnt == 4'h8) begin
                     d.oe = 1'b0;
                     d.st = ST_MACK;
                  end else begin
                     d.sh = {q.sh[6:0], 1'b0};
                     d.oe = ~q.sh[6];
                  end
               end
            end
            ST_MACK: begin
               if (rise) begin
                  d.nack = q.sda_s2;
                  if (!q.sda_s2) begin
                     d.ptr = q.ptr + 8'h01;
                  end
               end
               if (fall) begin
                  if (q.nack) begin
                     d.st = ST_IDLE; // host ends the read with not-acknowledge
                  end else begin
                     d.st = ST_TX;
                     d.sh = rd_data;
                     d.oe = ~rd_data[7];
                     d.cnt = 4'h0;
                  end
               end
            end
            ST_IDLE: d.oe = 1'b0;
            default: begin
               d.st = ST_IDLE;
               d.oe = 1'b0;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1,
                st: ST_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00, idx: 2'h0, rw: 1'b0, nack: 1'b0,
                oe: 1'b0, wr: '{en: 1'b0, addr: 8'h00, data: 8'h00}};
      end else begin
         q <= d;
      end
   end

   // register storage
   acrb_regs u_regs (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .wr_in(q.wr),
      .rd_addr_in(q.ptr),
      .rd_data_out(rd_data),
      .ctrl_out(ctrl_out)
   );

   // pin and control outputs
   assign sda_out = 1'b0; // open drain: only ever pulls low
   assign sda_oe_out = q.oe;
   assign clip_threshold_out = {ctrl_out.clip_threshold_hi, clip_mid_in, clip_low_in};
   assign power_stage_en_out = ctrl_out.amp_shutdown_n & ~ctrl_out.amp_sleep;
   assign logic_supply_en_out = ctrl_out.amp_shutdown_n;

   // protocol checks
   idle_release_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      q.st == ST_IDLE |-> !sda_oe_out)
      else $error("sda driven while idle");
   stop_idle_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (stop && !start) |=> q.st == ST_IDLE && !sda_oe_out)
      else $error("stop did not end transfer");
   write_ack_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      q.wr.en |-> q.st == ST_ACK && sda_oe_out)
      else $error("data write not acknowledged");
   power_stage_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ctrl_out.amp_sleep |-> !power_stage_en_out ##0 logic_supply_en_out == ctrl_out.amp_shutdown_n)
      else $error("power stage enabled in sleep");
   shutdown_off_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !ctrl_out.amp_shutdown_n |-> !power_stage_en_out && !logic_supply_en_out)
      else $error("supply enabled in shutdown");

   // bus timing checks
   addr_match_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (q.st == ST_RX && fall && q.cnt == 4'h8 && q.idx == 2'h0 && q.sh[7:1] == DEV_ADDR) |=>
      q.st == ST_ACK && sda_oe_out)
      else $error("own address not acknowledged");
   addr_miss_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (q.st == ST_RX && fall && q.cnt == 4'h8 && q.idx == 2'h0 && q.sh[7:1] != DEV_ADDR) |=>
      q.st == ST_IDLE && !sda_oe_out)
      else $error("foreign address acknowledged");
   scl_high_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (q.scl_s2 && q.scl_p && !start && !stop) |=> $stable(sda_oe_out))
      else $error("sda changed while scl high");
   tx_bit_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      q.st == ST_TX |-> sda_oe_out == !q.sh[7])
      else $error("read bit does not match data");
   read_end_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (q.st == ST_MACK && fall && q.nack) |=> q.st == ST_IDLE && !sda_oe_out)
      else $error("read not ended after not-acknowledge");
endmodule

// ---- inc/acrb_pkg.sv ----
/*
 amp control register bank: shared constants, types and the register map.
 assumes one system clock and an active-high asynchronous reset everywhere.
*/
// How it works
// - clip threshold top six bits from power
// - sleep bit disables power stage only
// - shutdown low powers down both domains
// - bit seven set bypasses highpass filter
// - boost field adds zero to eighteen dB
// - speed bit selects single or double rates
// - three-bit field selects serial input format
// - fade bit enables volume fading, resets set
// - right mute bit forces half duty output
// - left mute bit forces half duty output
// - identification register returns a fixed code
// - write: address, register, data, each acknowledged
// - read: pointer write, restart, bytes back until not-acknowledge
package acrb_pkg;
   // register offsets
   localparam logic [7:0] ADDR_ID = 8'h00;
   localparam logic [7:0] ADDR_PWR = 8'h01;
   localparam logic [7:0] ADDR_DIG = 8'h02;
   localparam logic [7:0] ADDR_VOL = 8'h03;
   // reset values
   localparam logic [7:0] RST_PWR = 8'hfd;
   localparam logic [7:0] RST_DIG = 8'h14;
   localparam logic [7:0] RST_VOL = 8'h80;
   // writable bit masks, the rest is read-only
   localparam logic [7:0] MASK_PWR = 8'hff;
   localparam logic [7:0] MASK_DIG = 8'hbf;
   localparam logic [7:0] MASK_VOL = 8'h83;
   // field positions
   localparam int PWR_CLIP_LSB = 2;
   localparam int PWR_SLEEP = 1;
   localparam int PWR_SD_N = 0;
   localparam int DIG_HPF = 7;
   localparam int DIG_BOOST_LSB = 4;
   localparam int DIG_SPEED = 3;
   localparam int DIG_FMT_LSB = 0;
   localparam int VOL_FADE = 7;
   localparam int VOL_MUTE_R = 1;
   localparam int VOL_MUTE_L = 0;
   // identification code, value arbitrary
   localparam logic [7:0] ID_CODE = 8'h5a;
   // default bus address of the device, value arbitrary
   localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;

   typedef enum logic [2:0] {
      FMT_RJ24 = 3'h0,
      FMT_RJ20 = 3'h1,
      FMT_RJ18 = 3'h2,
      FMT_RJ16 = 3'h3,
      FMT_I2S = 3'h4,
      FMT_LJ = 3'h5
   } acrb_fmt_t;

   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } acrb_wr_t;

   typedef struct packed {
      logic [5:0] clip_threshold_hi;
      logic amp_sleep;
      logic amp_shutdown_n;
      logic highpass_skip;
      logic [1:0] boost;
      logic rate_speed_select;
      acrb_fmt_t audio_format;
      logic fade_enable;
      logic mute_right;
      logic mute_left;
   } acrb_ctrl_t;
endpackage

// ---- core/acrb_regs.sv ----
/*
 register storage of the amp control bank with read mux and field outputs.
 assumes write strobes and read address come from logic on the same clock.
*/
`timescale 1ns/1ps
module acrb_regs (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input acrb_pkg::acrb_wr_t wr_in,
   input wire logic [7:0] rd_addr_in,
   output logic [7:0] rd_data_out,
   output acrb_pkg::acrb_ctrl_t ctrl_out
);
   typedef struct packed {
      logic [7:0] pwr;
      logic [7:0] dig;
      logic [7:0] vol;
   } acrb_regs_t;

   acrb_regs_t q, d;

   // masked byte write, read-only bits keep their value
   function automatic logic [7:0] acrb_merge(input logic [7:0] old, input logic [7:0] val, input logic [7:0] m);
      acrb_merge = (old & ~m) | (val & m);
   endfunction

   // write decode
   always_comb begin
      d = q;
      if (wr_in.en) begin
         case (wr_in.addr)
            acrb_pkg::ADDR_PWR: d.pwr = acrb_merge(q.pwr, wr_in.data, acrb_pkg::MASK_PWR);
            acrb_pkg::ADDR_DIG: d.dig = acrb_merge(q.dig, wr_in.data, acrb_pkg::MASK_DIG);
            acrb_pkg::ADDR_VOL: d.vol = acrb_merge(q.vol, wr_in.data, acrb_pkg::MASK_VOL);
            default: d = q; // identification and unmapped ignore writes
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '{pwr: acrb_pkg::RST_PWR, dig: acrb_pkg::RST_DIG, vol: acrb_pkg::RST_VOL};
      end else begin
         q <= d;
      end
   end

   // read mux, unmapped offsets read zero
   always_comb begin
      case (rd_addr_in)
         acrb_pkg::ADDR_ID: rd_data_out = acrb_pkg::ID_CODE;
         acrb_pkg::ADDR_PWR: rd_data_out = q.pwr;
         acrb_pkg::ADDR_DIG: rd_data_out = q.dig;
         acrb_pkg::ADDR_VOL: rd_data_out = q.vol;
         default: rd_data_out = 8'h00;
      endcase
   end

   // field outputs
   assign ctrl_out.clip_threshold_hi = q.pwr[acrb_pkg::PWR_CLIP_LSB +: 6];
   assign ctrl_out.amp_sleep = q.pwr[acrb_pkg::PWR_SLEEP];
   assign ctrl_out.amp_shutdown_n = q.pwr[acrb_pkg::PWR_SD_N];
   assign ctrl_out.highpass_skip = q.dig[acrb_pkg::DIG_HPF];
   assign ctrl_out.boost = q.dig[acrb_pkg::DIG_BOOST_LSB +: 2];
   assign ctrl_out.rate_speed_select = q.dig[acrb_pkg::DIG_SPEED];
   assign ctrl_out.audio_format = acrb_pkg::acrb_fmt_t'(q.dig[acrb_pkg::DIG_FMT_LSB +: 3]);
   assign ctrl_out.fade_enable = q.vol[acrb_pkg::VOL_FADE];
   assign ctrl_out.mute_right = q.vol[acrb_pkg::VOL_MUTE_R];
   assign ctrl_out.mute_left = q.vol[acrb_pkg::VOL_MUTE_L];

   // checks on the stored state
   reset_values_a: assert property (@(posedge clk_sys_in) $fell(rst_in) |->
      q.dig == acrb_pkg::RST_DIG && q.vol == acrb_pkg::RST_VOL && q.pwr == acrb_pkg::RST_PWR)
      else $error("register reset values wrong");
   pwr_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (wr_in.en && wr_in.addr == acrb_pkg::ADDR_PWR) |=> q.pwr == $past(wr_in.data))
      else $error("power register write lost");
   ro_bits_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      q.dig[6] == 1'b0 && q.vol[6:2] == 5'h00)
      else $error("read-only bit changed");
   id_read_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      rd_addr_in == acrb_pkg::ADDR_ID |-> rd_data_out == acrb_pkg::ID_CODE)
      else $error("identification read wrong");
   idle_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !wr_in.en |=> $stable(q))
      else $error("register changed without write");
endmodule

// ---- verif/acrb_host_model.sv ----
/*
 two-wire bus host model that drives the clock and data pins of the bank.
 assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/1ps
module acrb_host_model (
   input wire logic clk_in,
   input wire logic sda_line_in,
   output logic scl_out,
   output logic sda_low_out
);
   // idle bus: clock high, data released
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // one bit: data moves while scl is low and is sampled while scl is high
   task automatic bit_io(input logic b, output logic seen);
      @(posedge clk_in) scl_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      sda_low_out <= ~b;
      repeat (5) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      seen = sda_line_in;
      repeat (3) @(posedge clk_in);
   endtask
   // start (also repeated start) or stop: data edge while scl is high
   task automatic cond(input logic is_start);
      @(posedge clk_in) scl_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      sda_low_out <= ~is_start;
      repeat (5) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (5) @(posedge clk_in);
      sda_low_out <= is_start;
      repeat (5) @(posedge clk_in);
   endtask
   // byte out msb first, then the device's acknowledge slot
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   // byte in msb first, then acknowledge or not-acknowledge from the host
   task automatic get_byte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(nack, s);
   endtask
endmodule

// ---- verif/amp_control_register_bank_tb.sv ----
/*
 self-checking bench of the register bank against a register model.
 assumes the host model file is compiled before this one.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module amp_control_register_bank_tb;
   localparam logic [6:0] DEV = acrb_pkg::DEV_ADDR_DEF;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic scl, sda_low, sda_out, sda_oe, pse, lse;
   logic [7:0] clip_mid = 8'h00;
   logic [5:0] clip_low = 6'h00;
   logic [19:0] clip_thr;
   acrb_pkg::acrb_ctrl_t ctrl;
   wire sda_line;
   int fail_count = 0;
   int num_checks = 0;
   logic [7:0] mdl [0:3];
   logic [7:0] ro_list [4] = '{8'h00, 8'h02, 8'h03, 8'h07};
   // clock and open-drain line with pull-up
   always #12.5 clk_sys_in = ~clk_sys_in;
   assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
   acrb_top #(.DEV_ADDR(DEV)) u_acrb_top (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe), .clip_mid_in(clip_mid),
      .clip_low_in(clip_low), .ctrl_out(ctrl), .clip_threshold_out(clip_thr),
      .power_stage_en_out(pse), .logic_supply_en_out(lse));
   acrb_host_model u_acrb_host_model (.clk_in(clk_sys_in), .sda_line_in(sda_line), .scl_out(scl),
      .sda_low_out(sda_low));
   // writable bits of each offset, zero where nothing is writable
   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         8'h01: return 8'hff;
         8'h02: return 8'hbf;
         8'h03: return 8'h83;
         default: return 8'h00;
      endcase
   endfunction
   // model registers after reset
   task automatic mdl_reset();
      mdl[0] = acrb_pkg::ID_CODE;
      mdl[1] = 8'hfd;
      mdl[2] = 8'h14;
      mdl[3] = 8'h80;
   endtask
   // control outputs follow the model registers
   task automatic check_outs();
      acrb_pkg::acrb_ctrl_t e;
      e = {mdl[1], mdl[2][7], mdl[2][5:0], mdl[3][7], mdl[3][1:0]};
      `CHK("ctrl", e, ctrl)
      `CHK("clip", {mdl[1][7:2], clip_mid, clip_low}, clip_thr)
      `CHK("pwr_en", mdl[1][0] & ~mdl[1][1], pse)
      `CHK("logic_en", mdl[1][0], lse)
   endtask
   // single-byte register write, then compare all control outputs
   task automatic reg_write(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
      logic k;
      u_acrb_host_model.cond(1'b1);
      u_acrb_host_model.put_byte({dev, 1'b0}, k);
      `CHK("addr_ack", dev == DEV, k)
      if (k) begin
         u_acrb_host_model.put_byte(a, k);
         u_acrb_host_model.put_byte(d, k);
         `CHK("data_ack", 1'b1, k)
         if (a < 8'h04) mdl[a[1:0]] = (mdl[a[1:0]] & ~wmask(a)) | (d & wmask(a));
      end
      u_acrb_host_model.cond(1'b0);
      check_outs();
   endtask
   // pointer write, repeated start, n bytes back, host acknowledges all but the last
   task automatic reg_read(input logic [7:0] a, input int n);
      logic k;
      logic [7:0] d;
      u_acrb_host_model.cond(1'b1);
      u_acrb_host_model.put_byte({DEV, 1'b0}, k);
      u_acrb_host_model.put_byte(a, k);
      u_acrb_host_model.cond(1'b1);
      u_acrb_host_model.put_byte({DEV, 1'b1}, k);
      `CHK("rd_ack", 1'b1, k)
      for (int j = 0; j < n; j++) begin
         u_acrb_host_model.get_byte(j == n - 1, d);
         `CHK("rd_data", (int'(a) + j < 4) ? mdl[2'(int'(a) + j)] : 8'h00, d)
      end
      u_acrb_host_model.cond(1'b0);
   endtask
   // verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      void'($urandom(32'h91de));
      mdl_reset();
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      check_outs();
      for (int a = 0; a < 5; a++) reg_read(8'(a), 1);
      reg_read(8'h02, 3); // burst read across the map end
      // every format, boost, power and mute code, fade bit from the loop count, random other bits
      for (int i = 0; i < 8; i++) begin
         clip_mid <= 8'($urandom);
         clip_low <= 6'($urandom);
         reg_write(DEV, 8'h01, {6'($urandom), 2'(i)});
         reg_write(DEV, 8'h02, {1'($urandom), 1'b0, 2'(i), 1'($urandom), 3'(i % 6)});
         reg_write(DEV, 8'h03, {1'(i >> 2), 5'h00, 2'(i)});
         reg_read(8'(1 + i % 3), 1);
      end
      // read-only places and an unmapped offset take ones, format code kept legal
      foreach (ro_list[j]) begin
         reg_write(DEV, ro_list[j], 8'hfd);
         reg_read(ro_list[j], 1);
      end
      // a foreign device address is left unanswered
      reg_write(DEV ^ 7'h01, 8'h01, 8'h00);
      // reset in mid-run restores every field
      @(posedge clk_sys_in) rst_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      mdl_reset();
      repeat (3) @(posedge clk_sys_in);
      check_outs();
      reg_read(8'h03, 1);
      final_report();
   end
   // watchdog well beyond the expected run length
   initial begin
      #1500000;
      fail_count++;
      final_report();
   end
endmodule
